// ==== idm_ctrl.sv ====
`timescale 1ns/10ps
module idm_ctrl
  import idm_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // on-chip requests
  input  wire logic        timer_overflow_request,
  input  wire logic        compare_match_request_a,
  input  wire logic        compare_match_request_b,
  input  wire logic        watchdog_request,
  // request pins
  input  wire logic        nmi_pin,
  input  wire logic        capture_pin_request_a,
  input  wire logic        capture_pin_request_b,
  input  wire logic        external_pin_request_c,
  input  wire logic        external_pin_request_d,
  // cpu side
  input  wire logic        cpu_ready,
  input  wire logic        global_interrupt_enable,
  input  wire logic        break_instruction,
  input  wire logic        bank_switch_break_instruction,
  input  wire logic [7:0]  brk_operand,
  input  wire logic        invalid_opcode,
  input  wire logic        interrupt_return_from_bank,
  input  wire logic        break_return_from_bank,
  output logic             cpu_hold,
  output logic             cpu_vector,
  output logic      [15:0] cpu_vector_addr,
  output logic             cpu_ctx,
  output logic      [2:0]  cpu_bank,
  output logic             cpu_ctx_from_break,
  output logic             cpu_restore,
  // data memory
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             mem_word,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic [15:0] mem_rdata
);

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic [1:0] rst_q;
  logic       sys_rst_n;
  logic [4:0] pin_s1, pin_s2, pin_s3;
  wire  [4:0] pin_raw = {external_pin_request_d, external_pin_request_c,
                         capture_pin_request_b, capture_pin_request_a, nmi_pin};
  wire  [4:0] pin_rise = pin_s2 & ~pin_s3;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rst_q <= 2'h0;
    else        rst_q <= {rst_q[0], 1'b1};
  end
  assign sys_rst_n = rst_q[1];

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // index order is default priority order
  wire [NSRC-1:0] req_in = {pin_rise[4], pin_rise[3], compare_match_request_b,
                            compare_match_request_a, pin_rise[2], pin_rise[1],
                            timer_overflow_request};

  // ****************************************
  // per-source channel state
  // ****************************************
  logic [CTL_W-1:0] ctrl_r [NSRC];
  logic [CNT_W-1:0] cnt_r  [NSRC];
  logic [15:0]      rptr_r [NSRC];
  logic [15:0]      bptr_r [NSRC];
  logic [15:0]      last_r [NSRC];
  logic [NSRC-1:0]  pend, vec_force, mask_v;
  logic [2*NSRC-1:0] lvl_v;
  logic             nmi_pend, wdt_pend, trap_pend, brk_pend, bcs_pend;
  logic [2:0]       bcs_bank;
  logic             ret_mismatch;
  idm_state_t       state;
  logic [IDX_W-1:0] cur;

  for (genvar g = 0; g < NSRC; g++) begin : g_fld
    assign mask_v[g]         = ctrl_r[g][CTL_MASK];
    assign lvl_v[2*g +: 2]   = ctrl_r[g][CTL_PRIO_LSB +: 2];
  end

  // ****************************************
  // arbitration
  // ****************************************
  logic             pick_hit;
  logic [IDX_W-1:0] pick_idx;
  wire [NSRC-1:0] macro_v;
  for (genvar g = 0; g < NSRC; g++) begin : g_ms
    assign macro_v[g] = ctrl_r[g][CTL_HM_LSB +: 2] == hm_macro;
  end
  // macro service still runs while the cpu masks interrupts globally
  wire [NSRC-1:0] elig = pend & ~mask_v &
                         ((macro_v & ~vec_force) | {NSRC{global_interrupt_enable}});

  idm_prio_pick #(
    .NSRC_P (NSRC),
    .LVL_W  (2)
  ) u_pick (
    .req    (elig),
    .level  (lvl_v),
    .hit    (pick_hit),
    .idx    (pick_idx)
  );

  wire             take      = state == st_idle && cpu_ready;
  wire             take_nmi  = take && nmi_pend;
  wire             take_wdt  = take && !nmi_pend && wdt_pend;
  wire             take_trap = take && !nmi_pend && !wdt_pend && trap_pend;
  wire             take_brk  = take && !nmi_pend && !wdt_pend && !trap_pend && brk_pend;
  wire             take_bcs  = take && !nmi_pend && !wdt_pend && !trap_pend && !brk_pend
                               && bcs_pend;
  wire             sys_any   = nmi_pend | wdt_pend | trap_pend | brk_pend | bcs_pend;
  wire             take_mask = take && !sys_any && pick_hit;
  wire [CTL_W-1:0] pick_ctl  = ctrl_r[pick_idx];
  wire             pick_ms   = pick_ctl[CTL_HM_LSB +: 2] == hm_macro && !vec_force[pick_idx];
  wire             pick_cs   = pick_ctl[CTL_HM_LSB +: 2] == hm_ctx && global_interrupt_enable;
  wire [15:0]      sys_vec   = nmi_pend ? VEC_NMI : wdt_pend ? VEC_WDT :
                               trap_pend ? VEC_TRAP : VEC_BRK;

  // ****************************************
  // macro service datapath
  // ****************************************
  wire [CTL_W-1:0] cur_ctl  = ctrl_r[cur];
  wire idm_sub_t   cur_sub  = idm_sub_t'(cur_ctl[CTL_SUB_LSB +: 3]);
  wire             cur_dif  = cur_sub == difference_submode ||
                              cur_sub == difference_pointer_submode;
  wire             cur_word = cur_ctl[CTL_WORD] | cur_dif;
  wire [7:0]       cur_cnt  = cnt_r[cur];
  wire [15:0]      cur_buf  = buf_addr(cur_sub, bptr_r[cur], cur_cnt, cur_word);
  wire             sfr_src  = cur_dif | ~cur_ctl[CTL_DIR];
  wire             up_cnt   = cur_sub == counter_submode && !cur_ctl[CTL_DOWN];
  wire [7:0]       next_cnt = up_cnt ? cur_cnt + 8'h01 : cur_cnt - 8'h01;
  wire [15:0]      diff_val = mem_rdata - last_r[cur];
  wire [15:0]      step     = cur_word ? 16'h0002 : 16'h0001;

  wire [NSRC-1:0] pend_clr  = take_mask ? onehot(pick_idx) : '0;
  wire [NSRC-1:0] force_set = (state == st_ms_upd && next_cnt == 8'h00) ? onehot(cur) : '0;
  wire [NSRC-1:0] force_clr = (take_mask && !pick_ms && !pick_cs) ? onehot(pick_idx) : '0;

  // ****************************************
  // pending flags, set wins over clear
  // ****************************************
  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pend      <= '0;
      vec_force <= '0;
      nmi_pend  <= 1'b0;
      wdt_pend  <= 1'b0;
      trap_pend <= 1'b0;
      brk_pend  <= 1'b0;
      bcs_pend  <= 1'b0;
      bcs_bank  <= 3'h0;
    end else begin
      // terminal count raises its own request, so the forced vector needs no new event
      pend      <= (pend & ~pend_clr) | req_in | force_set;
      vec_force <= (vec_force & ~force_clr) | force_set;
      nmi_pend  <= (nmi_pend & ~take_nmi) | pin_rise[0];
      wdt_pend  <= (wdt_pend & ~take_wdt) | watchdog_request;
      trap_pend <= (trap_pend & ~take_trap) | invalid_opcode;
      brk_pend  <= (brk_pend & ~take_brk) | break_instruction;
      bcs_pend  <= (bcs_pend & ~take_bcs) | bank_switch_break_instruction;
      if (bank_switch_break_instruction) bcs_bank <= brk_operand[2:0];
    end
  end

  // ****************************************
  // channel storage
  // ****************************************
  wire [2:0] ra_src = reg_addr[6:4];
  wire       ra_in  = !reg_addr[7] && ra_src < 3'(NSRC);
  wire [2:0] ra_idx = ra_in ? ra_src : 3'h0;
  wire       wr_src = reg_wr && ra_in;

  // hardware updates come last so they win over a colliding bus write
  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      for (int i = 0; i < NSRC; i++) begin
        ctrl_r[i] <= CTL_RST;
        cnt_r[i]  <= 8'h00;
        rptr_r[i] <= 16'h0000;
        bptr_r[i] <= 16'h0000;
        last_r[i] <= 16'h0000;
      end
    end else begin
      if (wr_src) begin
        case (reg_addr[3:2])
          FLD_CTRL:  ctrl_r[ra_idx] <= reg_wdata[CTL_W-1:0];
          FLD_COUNT: cnt_r[ra_idx]  <= reg_wdata[CNT_W-1:0];
          FLD_PTRS: begin
            rptr_r[ra_idx] <= reg_wdata[15:0];
            bptr_r[ra_idx] <= reg_wdata[31:16];
          end
          default:   last_r[ra_idx] <= reg_wdata[15:0];
        endcase
      end
      if (state == st_ms_dat && cur_dif) last_r[cur] <= mem_rdata;
      if (state == st_ms_upd) begin
        cnt_r[cur] <= next_cnt;
        if (cur_sub == block_move_pointer_submode) bptr_r[cur] <= bptr_r[cur] + step;
      end
    end
  end

  // ****************************************
  // handling sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state              <= st_idle;
      cur                <= '0;
      cpu_vector         <= 1'b0;
      cpu_vector_addr    <= VEC_RESET;
      cpu_ctx            <= 1'b0;
      cpu_bank           <= 3'h0;
      cpu_ctx_from_break <= 1'b0;
      mem_addr           <= 16'h0000;
      mem_wdata          <= 16'h0000;
      mem_word           <= 1'b0;
      mem_rd             <= 1'b0;
      mem_wr             <= 1'b0;
    end else begin
      cpu_vector <= 1'b0;
      cpu_ctx    <= 1'b0;
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      case (state)
        st_idle: begin
          if (take_nmi || take_wdt || take_trap || take_brk) begin
            cpu_vector      <= 1'b1;
            cpu_vector_addr <= sys_vec;
          end else if (take_bcs) begin
            cpu_ctx            <= 1'b1;
            cpu_bank           <= bcs_bank;
            cpu_ctx_from_break <= 1'b1;
          end else if (take_mask) begin
            cur <= pick_idx;
            if (pick_ms) begin
              state <= st_ms_rd;
            end else if (pick_cs) begin
              mem_rd   <= 1'b1;
              mem_word <= 1'b0;
              mem_addr <= vec_of(pick_idx);
              state    <= st_cs_wait;
            end else begin
              cpu_vector      <= 1'b1;
              cpu_vector_addr <= vec_of(pick_idx);
            end
          end
        end
        st_ms_rd: begin
          if (cur_sub == counter_submode) begin
            state <= st_ms_upd;
          end else begin
            mem_rd   <= 1'b1;
            mem_word <= cur_word;
            mem_addr <= sfr_src ? rptr_r[cur] : cur_buf;
            state    <= st_ms_wait;
          end
        end
        st_ms_wait: state <= st_ms_dat;
        st_ms_dat: begin
          mem_wr    <= 1'b1;
          mem_addr  <= sfr_src ? cur_buf : rptr_r[cur];
          mem_wdata <= cur_dif ? diff_val : mem_rdata;
          state     <= st_ms_upd;
        end
        st_ms_upd:  state <= st_idle;
        st_cs_wait: state <= st_cs_dat;
        st_cs_dat: begin
          cpu_ctx            <= 1'b1;
          cpu_bank           <= mem_rdata[2:0];
          cpu_ctx_from_break <= 1'b0;
          state              <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  assign cpu_hold = state != st_idle;

  // ****************************************
  // bank return check
  // ****************************************
  // only the latest switch is tracked; nested switches rely on cpu-held banks
  wire mism_clr = reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_MISM];
  wire ret_bad  = (interrupt_return_from_bank && cpu_ctx_from_break) ||
                  (break_return_from_bank && !cpu_ctx_from_break);
  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      cpu_restore  <= 1'b0;
      ret_mismatch <= 1'b0;
    end else begin
      cpu_restore  <= (interrupt_return_from_bank || break_return_from_bank) && !ret_bad;
      ret_mismatch <= (ret_mismatch & ~mism_clr) | ret_bad;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  wire [31:0] src_word = reg_addr[3:2] == FLD_CTRL  ? {21'h000000, ctrl_r[ra_idx]} :
                         reg_addr[3:2] == FLD_COUNT ? {24'h000000, cnt_r[ra_idx]} :
                         reg_addr[3:2] == FLD_PTRS  ? {bptr_r[ra_idx], rptr_r[ra_idx]} :
                                                      {16'h0000, last_r[ra_idx]};
  wire [31:0] status   = {12'h000, ret_mismatch, cpu_ctx_from_break, vec_force, pend, state};
  wire [31:0] rd_mux   = ra_in ? src_word : (reg_addr == ADDR_STATUS ? status : 32'h0);

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) reg_rdata <= 32'h0;
    else            reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!sys_rst_n);

  sequence s_cpu_quiet;
    !cpu_vector && !cpu_ctx && cpu_hold;
  endsequence

  a_nmi_vector: assert property (take_nmi |=> cpu_vector && cpu_vector_addr == VEC_NMI)
    else $error("nmi vector wrong");
  a_trap_vector: assert property (take_trap |=> cpu_vector && cpu_vector_addr == VEC_TRAP)
    else $error("trap vector wrong");
  a_mask_vector: assert property (take_mask && !pick_ms && !pick_cs
    |=> cpu_vector && cpu_vector_addr == vec_of($past(pick_idx)))
    else $error("maskable vector wrong");
  a_brk_bank_only: assert property (take_bcs |=> cpu_ctx && cpu_ctx_from_break && !cpu_vector)
    else $error("bank break not switched");
  a_prio_top: assert property (elig[0] && lvl_v[1:0] == 2'h0 |-> pick_hit && pick_idx == 0)
    else $error("index zero not chosen");
  a_pick_valid: assert property (pick_hit |-> elig[pick_idx])
    else $error("winner not eligible");
  a_macro_quiet: assert property (state == st_ms_rd |-> s_cpu_quiet [*2])
    else $error("cpu state touched by macro");
  a_macro_long: assert property (state == st_ms_rd && cur_sub != counter_submode
    |-> s_cpu_quiet [*4])
    else $error("cpu state touched by transfer");
  a_count_step: assert property (state == st_ms_upd && cur_sub == counter_submode
    |=> cnt_r[$past(cur)] == ($past(up_cnt) ? $past(cur_cnt) + 8'h01 : $past(cur_cnt) - 8'h01))
    else $error("counter step wrong");
  a_zero_vector: assert property (state == st_ms_upd && next_cnt == 8'h00
    |=> vec_force[$past(cur)])
    else $error("terminal count lost");
  a_block_copy: assert property (state == st_ms_dat && !cur_dif
    |=> mem_wr && mem_wdata == $past(mem_rdata))
    else $error("block item wrong");
  a_block_dec: assert property (state == st_ms_upd && cur_sub != counter_submode
    |=> cnt_r[$past(cur)] == $past(cur_cnt) - 8'h01)
    else $error("block count wrong");
  a_ptr_advance: assert property (state == st_ms_upd && cur_sub == block_move_pointer_submode
    |=> bptr_r[$past(cur)] == $past(bptr_r[cur]) + $past(step))
    else $error("pointer not advanced");
  a_dif_result: assert property (state == st_ms_dat && cur_dif
    |=> mem_wr && mem_wdata == $past(mem_rdata) - $past(last_r[cur]))
    else $error("difference wrong");
  a_last_copy: assert property (state == st_ms_dat && cur_dif
    |=> last_r[$past(cur)] == $past(mem_rdata))
    else $error("last value not kept");
  a_dif_word: assert property (state == st_ms_rd && cur_dif |=> mem_rd && mem_word)
    else $error("difference not word");
  a_difp_keep: assert property (state == st_ms_upd && cur_sub == difference_pointer_submode
    |=> bptr_r[$past(cur)] == $past(bptr_r[cur]))
    else $error("pointer moved");
  a_ctx_enable: assert property (state == st_cs_wait |-> $past(global_interrupt_enable))
    else $error("switch while disabled");
  a_ctx_bank: assert property (state == st_cs_dat
    |=> cpu_ctx && cpu_bank == $past(mem_rdata[2:0]) && !cpu_ctx_from_break)
    else $error("bank from table wrong");
  a_bank_break: assert property (take_bcs |=> cpu_bank == $past(bcs_bank))
    else $error("bank from operand wrong");
  a_ret_match: assert property (interrupt_return_from_bank && !cpu_ctx_from_break
    |=> cpu_restore)
    else $error("return not honoured");
  a_resume: assert property (state == st_ms_upd |=> !cpu_hold && !cpu_vector && !cpu_ctx)
    else $error("resume disturbed");

endmodule : idm_ctrl

// ==== idm_pkg.sv ====
package idm_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NSRC  = 7;
  localparam int IDX_W = 3;
  localparam int CTL_W = 11;
  localparam int CNT_W = 8;

  // ****************************************
  // vector table
  // ****************************************
  localparam logic [15:0] VEC_RESET     = 16'h0000;
  localparam logic [15:0] VEC_NMI       = 16'h0002;
  localparam logic [15:0] VEC_WDT       = 16'h0004;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
  localparam logic [15:0] VEC_TRAP      = 16'h003C;
  localparam logic [15:0] VEC_BRK       = 16'h003E;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h80;
  localparam logic [1:0] FLD_CTRL    = 2'h0;
  localparam logic [1:0] FLD_COUNT   = 2'h1;
  localparam logic [1:0] FLD_PTRS    = 2'h2;
  localparam logic [1:0] FLD_LAST    = 2'h3;
  localparam int CTL_HM_LSB   = 0;
  localparam int CTL_SUB_LSB  = 2;
  localparam int CTL_DIR      = 5;
  localparam int CTL_WORD     = 6;
  localparam int CTL_DOWN     = 7;
  localparam int CTL_PRIO_LSB = 8;
  localparam int CTL_MASK     = 10;
  localparam int STAT_MISM    = 19;
  localparam logic [CTL_W-1:0] CTL_RST = 11'h400;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    hm_vector = 2'h0,
    hm_macro  = 2'h1,
    hm_ctx    = 2'h2
  } idm_hmode_t;

  typedef enum logic [2:0] {
    counter_submode            = 3'h0,
    block_move_submode         = 3'h1,
    block_move_pointer_submode = 3'h2,
    difference_submode         = 3'h3,
    difference_pointer_submode = 3'h4
  } idm_sub_t;

  typedef enum logic [3:0] {
    st_idle    = 4'h0,
    st_ms_rd   = 4'h1,
    st_ms_wait = 4'h3,
    st_ms_dat  = 4'h2,
    st_ms_upd  = 4'h6,
    st_cs_wait = 4'h8,
    st_cs_dat  = 4'hC
  } idm_state_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] i);
    return VEC_MASK_BASE + {12'h000, i, 1'b0};
  endfunction : vec_of

  function automatic logic [NSRC-1:0] onehot(input logic [IDX_W-1:0] i);
    return {{(NSRC-1){1'b0}}, 1'b1} << i;
  endfunction : onehot

  // buffer address for the item about to be serviced
  function automatic logic [15:0] buf_addr(input idm_sub_t sub, input logic [15:0] base,
                                          input logic [7:0] cnt, input logic word);
    logic [15:0] c16;
    c16 = {8'h00, cnt};
    case (sub)
      block_move_pointer_submode: return base;
      difference_pointer_submode: return base - {c16[14:0], 1'b0} + 16'h0002;
      default: return word ? base + {c16[14:0], 1'b0} - 16'h0002 : base + c16 - 16'h0001;
    endcase
  endfunction : buf_addr

endpackage : idm_pkg

// ==== idm_prio_pick.sv ====
`timescale 1ns/10ps
module idm_prio_pick
  import idm_pkg::*;
#(
  parameter int NSRC_P = 7,
  parameter int LVL_W  = 2
) (
  // requests and their levels
  input  wire logic [NSRC_P-1:0]       req,
  input  wire logic [LVL_W*NSRC_P-1:0] level,
  // winner
  output logic                         hit,
  output logic [IDX_W-1:0]             idx
);

  if (NSRC_P < 1 || NSRC_P > (1 << IDX_W)) begin : g_chk
    $error("source count does not fit the index width");
  end

  // loops run downward so the last match is the lowest level, then lowest index
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int l = (1 << LVL_W) - 1; l >= 0; l--) begin
      for (int i = NSRC_P - 1; i >= 0; i--) begin
        if (req[i] && level[i*LVL_W +: LVL_W] == l[LVL_W-1:0]) begin
          hit = 1'b1;
          idx = i[IDX_W-1:0];
        end
      end
    end
  end

endmodule : idm_prio_pick

// ==== idm_mem_model.sv ====
`timescale 1ns/10ps
module idm_mem_model (
  // data memory port
  input  wire logic        core_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  output logic      [15:0] mem_rdata
);
  logic [15:0] ram [0:255];
  // between answers the lines toggle, so stale data is never taken for valid
  always @(posedge core_clk) begin
    if (mem_wr) ram[mem_addr[8:1]] <= mem_wdata;
    mem_rdata <= mem_rd ? ram[mem_addr[8:1]] : ~mem_rdata;
  end
  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 256; i++) ram[i] = 16'h1000 + 16'(i);
  end
endmodule : idm_mem_model

// ==== test_interrupt_dispatch_macro_service.sv ====
`timescale 1ns/10ps
module test_interrupt_dispatch_macro_service;
  import idm_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cpu_ready = 1'b1, global_interrupt_enable = 1'b1, nmi_pin = 1'b0;
  logic        capture_pin_request_a = 1'b0, capture_pin_request_b = 1'b0;
  logic        external_pin_request_c = 1'b0, external_pin_request_d = 1'b0;
  logic [7:0]  reg_addr = 8'h00, brk_operand = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [8:0]  ev = 9'h000;
  logic        break_return_from_bank, interrupt_return_from_bank, bank_switch_break_instruction;
  logic        invalid_opcode, break_instruction, watchdog_request, compare_match_request_b;
  logic        compare_match_request_a, timer_overflow_request, cpu_hold, cpu_vector, cpu_ctx;
  logic        cpu_ctx_from_break, cpu_restore, mem_word, mem_rd, mem_wr;
  logic [15:0] cpu_vector_addr, mem_addr, mem_wdata, mem_rdata;
  logic [2:0]  cpu_bank;
  logic [3:0]  outs;
  int          err_total = 0, tests_run = 0;
  // one bit per cpu or peripheral pulse, so several can fire in one cycle
  assign {break_return_from_bank, interrupt_return_from_bank, bank_switch_break_instruction,
          invalid_opcode, break_instruction, watchdog_request, compare_match_request_b,
          compare_match_request_a, timer_overflow_request} = ev;
  assign outs = {cpu_restore, cpu_ctx, cpu_hold, cpu_vector};
  always #4 core_clk = ~core_clk;
  idm_ctrl dut (.*);
  idm_mem_model mem (.core_clk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic pulse(input logic [8:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 9'h000;
  endtask : pulse
  task automatic await(input int k, input logic v);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      #1;
      if (outs[k] === v) break;
    end
    chk(i < 20, "wait bound");
    if (i == 20) conclude();
  endtask : await
  task automatic vec(input logic [8:0] m, input logic [15:0] v);
    pulse(m);
    await(0, 1'b1);
    chk(cpu_vector_addr === v, "vector address");
  endtask : vec
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d === 32'h0 && cpu_vector_addr === 16'h0000, "idle status");
    rd(8'h00, d);
    chk(d === 32'h0000_0400, "control reset");
    rd(8'hF0, d);
    chk(d === 32'h0, "unmapped read");
    vec(9'h010, 16'h003E);
    vec(9'h020, 16'h003C);
    vec(9'h008, 16'h0004);
    @(posedge core_clk) nmi_pin <= 1'b1;
    await(0, 1'b1);
    chk(cpu_vector_addr === 16'h0002, "nmi vector");
    @(posedge core_clk) nmi_pin <= 1'b0;
    $display("test reset and fixed vectors done");
    wr(8'h00, 32'h0);
    wr(8'h30, 32'h0);
    cpu_ready <= 1'b0;
    global_interrupt_enable <= 1'b0;
    pulse(9'h003);
    cpu_ready <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk(cpu_vector === 1'b0 && cpu_hold === 1'b0, "taken while disabled");
    global_interrupt_enable <= 1'b1;
    await(0, 1'b1);
    chk(cpu_vector_addr === 16'h0006, "first winner");
    await(0, 1'b1);
    chk(cpu_vector_addr === 16'h000C, "second winner");
    $display("test priority done");
    wr(8'h40, 32'h81);
    wr(8'h44, 32'h1);
    pulse(9'h004);
    await(0, 1'b1);
    chk(cpu_vector_addr === 16'h000E, "counter terminal vector");
    rd(8'h44, d);
    chk(d === 32'h0, "counter stepped down");
    wr(8'h30, 32'h49);
    wr(8'h34, 32'h2);
    wr(8'h38, 32'h0100_0020);
    pulse(9'h002);
    await(1, 1'b1);
    await(1, 1'b0);
    rd(8'h38, d);
    chk(d === 32'h0102_0020, "pointer step");
    chk(mem.ram[8'h80] === 16'h1010, "item moved");
    rd(8'h34, d);
    chk(d === 32'h1, "count left");
    wr(8'h10, 32'h11);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h0060_0040);
    wr(8'h1C, 32'h5);
    @(posedge core_clk) capture_pin_request_a <= 1'b1;
    await(1, 1'b1);
    await(1, 1'b0);
    @(posedge core_clk) capture_pin_request_a <= 1'b0;
    chk(mem.ram[8'h2F] === 16'h101B, "difference stored");
    rd(8'h1C, d);
    chk(d === 32'h1020, "last value kept");
    rd(8'h18, d);
    chk(d === 32'h0060_0040, "pointer kept");
    rd(8'h14, d);
    chk(d === 32'h1, "difference count");
    $display("test macro service done");
    brk_operand <= 8'hFD;
    pulse(9'h040);
    await(2, 1'b1);
    chk(cpu_bank === 3'h5 && cpu_ctx_from_break === 1'b1, "break bank");
    pulse(9'h080);
    #1 chk(cpu_restore === 1'b0, "refused return");
    rd(ADDR_STATUS, d);
    chk(d[STAT_MISM] === 1'b1, "wrong return kind");
    pulse(9'h100);
    #1 chk(cpu_restore === 1'b1, "break return");
    wr(8'h00, 32'h2);
    pulse(9'h001);
    await(2, 1'b1);
    chk(cpu_bank === 3'h3 && cpu_ctx_from_break === 1'b0, "request bank");
    pulse(9'h080);
    #1 chk(cpu_restore === 1'b1, "interrupt return");
    $display("test bank switch done");
    conclude();
  end
endmodule : test_interrupt_dispatch_macro_service
